// ===== src/tcos_defs.vh
`ifndef TCOS_DEFS_VH
`define TCOS_DEFS_VH

// Container frame geometry, one byte per stream clock
`define TCOS_FRAME_LEN      9'd428
`define TCOS_FRAME_LAST     9'd427
`define TCOS_V5_POS         9'd0
`define TCOS_N2_POS         9'd214

// Multiframe carried in N2 bits 7 and 8
`define TCOS_MF_FIRST       7'd1
`define TCOS_MF_LAST        7'd76
`define TCOS_MF_FAS_LAST    7'd8
`define TCOS_MF_TRACE_FIRST 7'd9
`define TCOS_MF_TRACE_LAST  7'd72
`define TCOS_MF_RDI         7'd73
`define TCOS_MF_ODI         7'd74
`define TCOS_FAS_PATTERN    16'hFFFE

// Register byte addresses
`define TCOS_ADDR_CTRL      12'h000
`define TCOS_ADDR_STATUS    12'h004
`define TCOS_ADDR_TRACE0    12'h010
`define TCOS_ADDR_TRACE1    12'h014
`define TCOS_ADDR_TRACE2    12'h018
`define TCOS_ADDR_TRACE3    12'h01C

// Register fields and reset values
`define TCOS_CTRL_ENABLE    0
`define TCOS_CTRL_RESET     32'h00000001
`define TCOS_TRACE_RESET    32'h00000000
`define TCOS_STAT_MF_MSB    6
`define TCOS_STAT_LOCKED    8
`define TCOS_STAT_SF        9

`endif

// ===== src/tcos_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser bank for signals from the stream clock side
module tcos_sync #(
    parameter W = 1
) (
    input  wire         clk,    // Sampling clock
    input  wire         reset,  // Synchronous reset, high
    input  wire [W-1:0] d,      // Asynchronous inputs
    output reg  [W-1:0] q       // Synchronised outputs
);

    reg [W-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (reset) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // tcos_sync

`default_nettype wire

// ===== src/tcos_overhead_source.v
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tcos_defs.vh"

// Overview of operation
// - Remote defect request sent in N2 bit 8 of multiframe frame 73.
// - N2 bits 7 and 8 form a 76-frame multiframe lasting 38 ms.
// - N2 bit 3 always sent as one.
// - N2 bit 4 follows the incoming signal-fail input.
// - Remote error value copied into N2 bit 5.
// - Outgoing defect request sent in N2 bit 7 of frame 74.
// - Outgoing error value copied into N2 bit 6.
// - Frames 1 to 8 carry alignment pattern FFFE in bits 7 and 8.
// - Frames 9 to 72 carry the transmit trace value.
// - Unused bits of frames 73 to 76 sent as zero.
// - Two-bit parity of each frame goes into next frame's N2 bits 1-2.
// - V5 bits 1-2 adjusted so path parity matches the rewritten container.
// - V5 bit 1 adjustment accounts for the previous frame's V5 bit 1 adjustment.
// - New V5 bit 1 from the five listed previous/current frame terms.
// - New V5 bit 2 uses the listed terms without previous adjusted bit.
// - Parity is even, one bit per bit position of every pair.
module tcos_overhead_source (
    input  wire        CLK,                     // 200 MHz system clock
    input  wire        RESET,                   // Synchronous reset, high
    input  wire        PSEL,                    // APB select
    input  wire        PENABLE,                 // APB access phase
    input  wire        PWRITE,                  // APB write when high
    input  wire [11:0] PADDR,                   // APB byte address
    input  wire [31:0] PWDATA,                  // APB write data
    output reg  [31:0] PRDATA,                  // APB read data
    output reg         PREADY,                  // APB ready
    output reg         PSLVERR,                 // APB error, unmapped
    input  wire [7:0]  ADAPTATION_SIDE_DATA,    // Incoming container byte
    input  wire        ADAPTATION_SIDE_CLK,     // Incoming stream clock
    input  wire        ADAPTATION_SIDE_FS,      // Incoming frame start
    input  wire        INCOMING_SIGNAL_FAIL,    // Incoming signal fail
    input  wire        REMOTE_DEFECT_REQUEST,   // Remote defect request
    input  wire        REMOTE_ERROR_VALUE,      // Remote error value
    input  wire        OUTGOING_DEFECT_REQUEST, // Outgoing defect request
    input  wire        OUTGOING_ERROR_VALUE,    // Outgoing error value
    output reg  [7:0]  CONNECTION_SIDE_DATA,    // Outgoing container byte
    output reg         CONNECTION_SIDE_CLK,     // Outgoing stream clock
    output reg         CONNECTION_SIDE_FS       // Outgoing frame start
);

    // Even parity per bit position of the pairs, {bit1 group, bit2 group}
    function [1:0] fold2;
        input [7:0] b;
        begin
            fold2 = {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
        end
    endfunction

    // Content of N2 bits 7 and 8 for a multiframe number
    function [1:0] mf_bits;
        input [6:0]   mf;
        input [127:0] trace;
        input         rdi;
        input         odi;
        reg   [6:0]   pos;
        reg   [15:0]  multiframe_alignment_pattern;
        begin
            pos = 7'd0;
            multiframe_alignment_pattern = `TCOS_FAS_PATTERN;
            if (mf <= `TCOS_MF_FAS_LAST) begin
                pos = (mf - `TCOS_MF_FIRST) << 1;
                mf_bits = {multiframe_alignment_pattern[4'd15 - pos[3:0]],
                           multiframe_alignment_pattern[4'd14 - pos[3:0]]};
            end else if (mf <= `TCOS_MF_TRACE_LAST) begin
                pos = (mf - `TCOS_MF_TRACE_FIRST) << 1;
                mf_bits = {trace[7'd127 - pos], trace[7'd126 - pos]};
            end else if (mf == `TCOS_MF_RDI) begin
                mf_bits = {1'b0, rdi};
            end else if (mf == `TCOS_MF_ODI) begin
                mf_bits = {odi, 1'b0};
            end else begin
                mf_bits = 2'b00;
            end
        end
    endfunction

    // Synchronised stream signals {clk, fs, data}
    wire [9:0] link_s;
    wire [7:0] in_data = link_s[7:0];
    wire       in_fs   = link_s[8];
    wire       in_ck   = link_s[9];

    reg         ck_d;
    reg         ck_out_d;
    reg [8:0]   byte_cnt;
    reg         locked;
    reg [6:0]   mf_cnt;
    reg [1:0]   bip_acc;
    reg [1:0]   bip_prev;
    reg         prev_ok;
    reg [1:0]   v5_in_prev;
    reg [1:0]   v5_out_prev;
    reg [7:0]   n2_in_prev;
    reg [7:0]   n2_out_prev;
    reg [31:0]  ctrl;
    reg [127:0] trace;

    reg [8:0]   next_byte_cnt;
    reg [6:0]   next_mf_cnt;
    reg [7:0]   next_data;
    reg [1:0]   next_bip_acc;
    reg [1:0]   f_in;
    reg [1:0]   f_out;
    reg [1:0]   mf_pair;
    reg [31:0]  next_rdata;
    reg         next_err;

    wire rise    = in_ck & ~ck_d;
    wire enable  = ctrl[`TCOS_CTRL_ENABLE];
    wire apb_acc = PSEL & PENABLE & PREADY;

    tcos_sync #(.W(10)) u_link_sync (
        .clk   (CLK),
        .reset (RESET),
        .d     ({ADAPTATION_SIDE_CLK, ADAPTATION_SIDE_FS,
                 ADAPTATION_SIDE_DATA}),
        .q     (link_s)
    );

    // Byte position and multiframe number for the byte now arriving
    always @* begin
        if (in_fs) begin
            next_byte_cnt = `TCOS_V5_POS;
        end else if (byte_cnt != `TCOS_FRAME_LAST) begin
            next_byte_cnt = byte_cnt + 9'd1;
        end else begin
            next_byte_cnt = byte_cnt;
        end
        if (!in_fs) begin
            next_mf_cnt = mf_cnt;
        end else if (mf_cnt == `TCOS_MF_LAST) begin
            next_mf_cnt = `TCOS_MF_FIRST;
        end else begin
            next_mf_cnt = mf_cnt + 7'd1;
        end
    end

    // Rewrite of V5 and N2, all other bytes pass through
    always @* begin
        f_in      = fold2(n2_in_prev);
        f_out     = fold2(n2_out_prev);
        mf_pair   = mf_bits(mf_cnt, trace, REMOTE_DEFECT_REQUEST,
                            OUTGOING_DEFECT_REQUEST);
        next_data = in_data;
        if (enable && in_fs && prev_ok) begin
            next_data[7] = v5_in_prev[1] ^ v5_out_prev[1]
                         ^ f_in[1] ^ f_out[1] ^ in_data[7];
            next_data[6] = v5_in_prev[0]
                         ^ f_in[0] ^ f_out[0] ^ in_data[6];
        end else if (enable && locked && !in_fs
                     && next_byte_cnt == `TCOS_N2_POS) begin
            next_data[7:6] = bip_prev;
            next_data[5]   = 1'b1;
            next_data[4]   = INCOMING_SIGNAL_FAIL;
            next_data[3]   = REMOTE_ERROR_VALUE;
            next_data[2]   = OUTGOING_ERROR_VALUE;
            next_data[1:0] = mf_pair;
        end
    end

    // Parity over the outgoing frame, including V5 and N2
    always @* begin
        if (in_fs) begin
            next_bip_acc = fold2(next_data);
        end else begin
            next_bip_acc = bip_acc ^ fold2(next_data);
        end
    end

    // Stream pipeline; output clock trails data by two cycles
    always @(posedge CLK) begin
        if (RESET) begin
            ck_d                 <= 1'b0;
            ck_out_d             <= 1'b0;
            CONNECTION_SIDE_CLK  <= 1'b0;
            CONNECTION_SIDE_DATA <= 8'h00;
            CONNECTION_SIDE_FS   <= 1'b0;
        end else begin
            ck_d                <= in_ck;
            ck_out_d            <= ck_d;
            CONNECTION_SIDE_CLK <= ck_out_d;
            if (rise) begin
                CONNECTION_SIDE_DATA <= next_data;
                CONNECTION_SIDE_FS   <= in_fs;
            end
        end
    end

    // Frame state, parity and previous-frame history
    always @(posedge CLK) begin
        if (RESET) begin
            byte_cnt    <= `TCOS_FRAME_LAST;
            locked      <= 1'b0;
            mf_cnt      <= `TCOS_MF_LAST;
            bip_acc     <= 2'b00;
            bip_prev    <= 2'b00;
            prev_ok     <= 1'b0;
            v5_in_prev  <= 2'b00;
            v5_out_prev <= 2'b00;
            n2_in_prev  <= 8'h00;
            n2_out_prev <= 8'h00;
        end else if (rise) begin
            byte_cnt <= next_byte_cnt;
            mf_cnt   <= next_mf_cnt;
            bip_acc  <= next_bip_acc;
            if (in_fs) begin
                locked      <= 1'b1;
                bip_prev    <= bip_acc;
                v5_in_prev  <= in_data[7:6];
                v5_out_prev <= next_data[7:6];
            end
            if (!in_fs && next_byte_cnt == `TCOS_N2_POS) begin
                n2_in_prev  <= in_data;
                n2_out_prev <= next_data;
                prev_ok     <= 1'b1;
            end
        end
    end

    // Register read decode
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (PADDR)
            `TCOS_ADDR_CTRL:   next_rdata = ctrl;
            `TCOS_ADDR_STATUS: begin
                next_rdata[`TCOS_STAT_MF_MSB:0] = mf_cnt;
                next_rdata[`TCOS_STAT_LOCKED]   = locked;
                next_rdata[`TCOS_STAT_SF]       = INCOMING_SIGNAL_FAIL;
            end
            `TCOS_ADDR_TRACE0: next_rdata = trace[127:96];
            `TCOS_ADDR_TRACE1: next_rdata = trace[95:64];
            `TCOS_ADDR_TRACE2: next_rdata = trace[63:32];
            `TCOS_ADDR_TRACE3: next_rdata = trace[31:0];
            default:           next_err   = 1'b1;
        endcase
    end

    // APB slave: one wait state, write lands when PREADY is sampled
    always @(posedge CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
            ctrl    <= `TCOS_CTRL_RESET;
            trace   <= {4{`TCOS_TRACE_RESET}};
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            if (PSEL && PENABLE && !PREADY) begin
                PRDATA  <= PWRITE ? 32'h00000000 : next_rdata;
                PSLVERR <= next_err;
            end else begin
                PRDATA  <= 32'h00000000;
                PSLVERR <= 1'b0;
            end
            if (apb_acc && PWRITE) begin
                case (PADDR)
                    `TCOS_ADDR_CTRL:   ctrl          <= PWDATA;
                    `TCOS_ADDR_TRACE0: trace[127:96] <= PWDATA;
                    `TCOS_ADDR_TRACE1: trace[95:64]  <= PWDATA;
                    `TCOS_ADDR_TRACE2: trace[63:32]  <= PWDATA;
                    `TCOS_ADDR_TRACE3: trace[31:0]   <= PWDATA;
                    default:           ctrl          <= ctrl;
                endcase
            end
        end
    end

endmodule // tcos_overhead_source

`default_nettype wire

// ===== sim/tcos_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcos_defs.vh"
// Port checks of the overhead source
module tcos_asserts (
    input wire logic        CLK,                  // Clock
    input wire logic        RESET,                // Reset
    input wire logic        PSEL,                 // Select
    input wire logic        PENABLE,              // Access
    input wire logic        PWRITE,               // Write
    input wire logic [11:0] PADDR,                // Address
    input wire logic [31:0] PWDATA,               // Write data
    input wire logic        PREADY,               // Ready
    input wire logic        PSLVERR,              // Error
    input wire logic        ADAPTATION_SIDE_CLK,  // Input clock
    input wire logic        INCOMING_SIGNAL_FAIL, // Signal fail
    input wire logic        REMOTE_ERROR_VALUE,   // Remote error
    input wire logic        OUTGOING_ERROR_VALUE, // Outgoing error
    input wire logic [7:0]  CONNECTION_SIDE_DATA, // Output byte
    input wire logic        CONNECTION_SIDE_CLK,  // Output clock
    input wire logic        CONNECTION_SIDE_FS    // Output frame start
);
    logic       oq;
    logic       en;
    logic       seen;
    logic [8:0] idx;
    logic       rise;
    logic       n2;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    assign rise = CONNECTION_SIDE_CLK & ~oq;
    assign n2 = rise & seen & en & ~CONNECTION_SIDE_FS & (idx == 9'h0D5);
    // Byte position from the outgoing frame start, enable from bus writes
    always_ff @(posedge CLK) begin
        oq <= CONNECTION_SIDE_CLK;
        if (RESET) begin
            seen <= 1'b0;
            idx <= 9'h000;
            en <= 1'b1;
        end else begin
            if (rise) begin
                seen <= seen | CONNECTION_SIDE_FS;
                idx <= CONNECTION_SIDE_FS ? 9'h000 : idx + 9'h001;
            end
            if (PSEL && PENABLE && PREADY && PWRITE
                && PADDR == `TCOS_ADDR_CTRL) begin
                en <= PWDATA[`TCOS_CTRL_ENABLE];
            end
        end
    end
    a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("ready missing after access");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held two cycles");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_clk_delay: assert property (
        $rose(ADAPTATION_SIDE_CLK) |-> ##[4:6] $rose(CONNECTION_SIDE_CLK))
        else $error("output clock not following input");
    a_data_hold: assert property (
        rise |=> $stable(CONNECTION_SIDE_DATA) && $stable(CONNECTION_SIDE_FS))
        else $error("byte changed after clock rise");
    a_fixed_bit: assert property (n2 |-> CONNECTION_SIDE_DATA[5])
        else $error("fixed bit not one");
    a_ais_bit: assert property (
        n2 |-> CONNECTION_SIDE_DATA[4] == $past(INCOMING_SIGNAL_FAIL, 3))
        else $error("incoming AIS bit wrong");
    a_rei_bit: assert property (
        n2 |-> CONNECTION_SIDE_DATA[3] == $past(REMOTE_ERROR_VALUE, 3))
        else $error("remote error bit wrong");
    a_oei_bit: assert property (
        n2 |-> CONNECTION_SIDE_DATA[2] == $past(OUTGOING_ERROR_VALUE, 3))
        else $error("outgoing error bit wrong");
endmodule // tcos_asserts
bind tcos_overhead_source tcos_asserts u_chk (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ADAPTATION_SIDE_CLK(ADAPTATION_SIDE_CLK),
    .INCOMING_SIGNAL_FAIL(INCOMING_SIGNAL_FAIL),
    .REMOTE_ERROR_VALUE(REMOTE_ERROR_VALUE),
    .OUTGOING_ERROR_VALUE(OUTGOING_ERROR_VALUE),
    .CONNECTION_SIDE_DATA(CONNECTION_SIDE_DATA),
    .CONNECTION_SIDE_CLK(CONNECTION_SIDE_CLK),
    .CONNECTION_SIDE_FS(CONNECTION_SIDE_FS)
);
`default_nettype wire

// ===== sim/tcos_stream_src.sv
`timescale 1ns/1ps
`default_nettype none
module tcos_stream_src (
    input  wire logic  run,  // Start sending
    output logic       sclk, // Stream clock, 64 ns
    output logic [7:0] data, // Container byte
    output logic       fs    // High on the first byte
);
    int n = 0;
    // Frames of 428 bytes, data changed on the falling edge
    initial begin
        sclk = 1'b0;
        data = 8'h00;
        fs = 1'b0;
        wait (run);
        #0.5;
        forever begin
            sclk = 1'b0;
            data = 8'($urandom);
            fs = (n == 0);
            n = (n + 1) % 428;
            #32 sclk = 1'b1;
            #32;
        end
    end
endmodule // tcos_stream_src
`default_nettype wire

// ===== sim/test_tandem_connection_overhead_source.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcos_defs.vh"
module test_tandem_connection_overhead_source;
    logic         clk = 1'b0, reset = 1'b1, run = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000, ta;
    logic [31:0]  pwdata = 32'h00000000, prdata, ad;
    logic [4:0]   ri = 5'h00;
    logic         pready, pslverr, sclk, sfs, oclk, ofs, sq, fq, oq;
    logic         aw, ae, efs, en = 1'b1;
    logic [7:0]   sdata, odata, e, ein, vin, vout, nin, nout, d, pacc;
    logic [7:0]   acc = 8'h00;
    logic [1:0]   mf;
    logic [15:0]  multiframe_alignment_pattern = `TCOS_FAS_PATTERN;
    logic [127:0] tr;
    logic [33:0]  aq[$];
    logic [8:0]   inq[$];
    int           miscompares = 0, checks_done = 0, frm = 0, pos = 0, k;
    tcos_overhead_source dut_u (
        .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .ADAPTATION_SIDE_DATA(sdata),
        .ADAPTATION_SIDE_CLK(sclk), .ADAPTATION_SIDE_FS(sfs),
        .INCOMING_SIGNAL_FAIL(ri[4]), .REMOTE_DEFECT_REQUEST(ri[3]),
        .REMOTE_ERROR_VALUE(ri[2]), .OUTGOING_DEFECT_REQUEST(ri[1]),
        .OUTGOING_ERROR_VALUE(ri[0]), .CONNECTION_SIDE_DATA(odata),
        .CONNECTION_SIDE_CLK(oclk), .CONNECTION_SIDE_FS(ofs)
    );
    tcos_stream_src src_u (.run(run), .sclk(sclk), .data(sdata), .fs(sfs));
    task automatic chk(input string n, input logic [31:0] x, g);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, xd, input logic xe);
        int n;
        aq.push_back({w, xd, xe});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin
            chk("ready", 1, 0);
            end_sim;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Expected outgoing byte from the noted input byte
    task check_byte;
        {efs, ein} = inq.pop_front();
        chk("frame start", efs, ofs);
        if (ofs) begin
            frm++;
            pos = 0;
            pacc = acc;
            acc = 8'h00;
        end else
            pos++;
        e = ein;
        d = nin ^ nout;
        if (en && pos == 0 && frm > 1) begin
            e[7] = ein[7] ^ vin[7] ^ vout[7] ^ ^(d & 8'hAA);
            e[6] = ein[6] ^ vin[6] ^ ^(d & 8'h55);
        end
        if (en && pos == 214) begin
            mf = frm < 9 ? multiframe_alignment_pattern[17 - 2 * frm -: 2]
                         : tr[145 - 2 * frm -: 2];
            e = {^(pacc & 8'hAA), ^(pacc & 8'h55), 1'b1, ri[4], ri[2], ri[0],
                 mf};
        end
        chk("outgoing byte", e, odata);
        acc ^= e;
        if (pos == 0) {vin, vout} = {ein, e};
        if (pos == 214) {nin, nout} = {ein, e};
    endtask
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // Note input bytes, new overhead inputs at each frame start
    always @(posedge clk) begin
        sq <= sclk;
        fq <= sfs;
        oq <= oclk;
        if (sclk && !sq)
            inq.push_back({sfs, sdata});
        if (sfs && !fq)
            ri <= 5'($urandom);
        if (oclk && !oq) begin
            if (inq.size() == 0) chk("byte queue", 1, 0);
            else check_byte();
        end
        if (pready === 1'b1) begin
            if (aq.size() == 0) chk("bus queue", 1, 0);
            else begin
                {aw, ad, ae} = aq.pop_front();
                if (!aw) chk("read data", ad, prdata);
                chk("slave error", ae, pslverr);
            end
        end
    end
    // Registers, then a run of frames
    initial begin
        void'($urandom(32'hE2565C5C));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        apb(1'b0, `TCOS_ADDR_CTRL, 32'h0, `TCOS_CTRL_RESET, 1'b0);
        apb(1'b0, `TCOS_ADDR_STATUS, 32'h0, 32'h0000004C, 1'b0);
        apb(1'b1, 12'h020, 32'hFFFFFFFF, 32'h0, 1'b1);
        apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
        for (k = 0; k < 4; k++) begin
            tr[127 - 32 * k -: 32] = $urandom;
            ta = `TCOS_ADDR_TRACE0 + 12'(4 * k);
            apb(1'b0, ta, 32'h0, `TCOS_TRACE_RESET, 1'b0);
            apb(1'b1, ta, tr[127 - 32 * k -: 32], 32'h0, 1'b0);
            apb(1'b0, ta, 32'h0, tr[127 - 32 * k -: 32], 1'b0);
        end
        run <= 1'b1;
        for (k = 0; k < 80000 && frm < 14; k++) @(posedge clk);
        // Switch to full pass-through, then one more frame
        apb(1'b1, `TCOS_ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        en = 1'b0;
        apb(1'b0, `TCOS_ADDR_STATUS, 32'h0,
            {22'h0, ri[4], 9'h10E}, 1'b0);
        for (k = 0; k < 8000 && frm < 15; k++) @(posedge clk);
        if (frm < 15) chk("frame count", 15, frm);
        end_sim;
    end
endmodule // test_tandem_connection_overhead_source
`default_nettype wire
